/* File: design/cfs_map.svh */
/*
  Constants of the card file selection and cyclic record block:
  file table, record geometry, status words, pointer codes.
  Assumes nothing; definitions only.
*/
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH
`define CFS_NREC 4'h8
`define CFS_REC_BYTES 16'h0004
`define CFS_REC_BITS 32
`define CFS_NFILE 8
`define CFS_PTR_UNSET 4'h0
`define CFS_REC_FIRST 4'h1
`define CFS_IDX_MF 3'h0
`define CFS_IDX_ADF 3'h1
`define CFS_IDX_DFA 3'h2
`define CFS_IDX_DFB 3'h3
`define CFS_IDX_EFA 3'h4
`define CFS_IDX_EFB 3'h5
`define CFS_IDX_EFC 3'h6
`define CFS_IDX_LOG 3'h7
`define CFS_FID_MF 16'h3f00
`define CFS_FID_ADF 16'h7f01
`define CFS_FID_DFA 16'h7f10
`define CFS_FID_DFB 16'h5f3a
`define CFS_FID_EFA 16'h2fe2
`define CFS_FID_EFB 16'h6f3a
`define CFS_FID_EFC 16'h6fad
`define CFS_FID_LOG 16'h6f80
`define CFS_FID_ALIAS 16'h7fff
`define CFS_SFI_NONE 5'h00
`define CFS_SFI_EFA 5'h02
`define CFS_SFI_EFB 5'h01
`define CFS_SFI_EFC 5'h03
`define CFS_SFI_LOG 5'h04
`define CFS_TAG_DESC 8'h82
`define CFS_SW_OK 16'h9000
`define CFS_SW_BAD_STRUCT 16'h6981
`define CFS_SW_COND 16'h6985
`define CFS_SW_NO_EF 16'h6986
`define CFS_SW_NOT_FOUND 16'h6a82
`define CFS_SW_NO_REC 16'h6a83
`define CFS_SW_BAD_INS 16'h6d00
`endif

/* File: design/cfs_pkg.sv */
/*
  Types and file table lookups of the card file selection block.
  Assumes cfs_map.svh is on the include path.
*/
`include "cfs_map.svh"
package cfs_pkg;
  typedef enum logic [2:0] {
    CFS_OP_SELECT, CFS_OP_READ_REC, CFS_OP_UPDATE_REC,
    CFS_OP_READ_BIN, CFS_OP_APP, CFS_OP_STATUS
  } cfs_op_t;
  typedef enum logic [1:0] {CFS_MODE_NEXT, CFS_MODE_PREV, CFS_MODE_CURR, CFS_MODE_ABS} cfs_mode_t;
  typedef enum logic [1:0] {CFS_KIND_DIR, CFS_KIND_BIN, CFS_KIND_CYC} cfs_kind_t;
  typedef enum logic {CFS_IDLE, CFS_RESP} cfs_state_t;
  typedef struct packed {
    cfs_op_t op;
    cfs_mode_t mode;
    logic [7:0] rec_num;
    logic [15:0] file_identifier;
    logic [2:0] app_dir;
    logic [`CFS_REC_BITS-1:0] wdata;
  } cfs_cmd_t;
  typedef struct packed {
    logic [15:0] sw;
    logic [`CFS_REC_BITS-1:0] data;
    logic [7:0] desc_tag;
    logic [15:0] rec_len;
    logic [7:0] rec_cnt;
    logic [15:0] file_identifier;
    logic [4:0] short_file_number;
  } cfs_rsp_t;

  function automatic logic [15:0] cfs_fid(input logic [2:0] idx);
    case (idx)
      `CFS_IDX_MF: cfs_fid = `CFS_FID_MF;
      `CFS_IDX_ADF: cfs_fid = `CFS_FID_ADF;
      `CFS_IDX_DFA: cfs_fid = `CFS_FID_DFA;
      `CFS_IDX_DFB: cfs_fid = `CFS_FID_DFB;
      `CFS_IDX_EFA: cfs_fid = `CFS_FID_EFA;
      `CFS_IDX_EFB: cfs_fid = `CFS_FID_EFB;
      `CFS_IDX_EFC: cfs_fid = `CFS_FID_EFC;
      default: cfs_fid = `CFS_FID_LOG;
    endcase
  endfunction

  function automatic logic [2:0] cfs_parent(input logic [2:0] idx);
    case (idx)
      `CFS_IDX_DFB, `CFS_IDX_EFB: cfs_parent = `CFS_IDX_DFA;
      `CFS_IDX_EFC, `CFS_IDX_LOG: cfs_parent = `CFS_IDX_ADF;
      default: cfs_parent = `CFS_IDX_MF;
    endcase
  endfunction

  function automatic cfs_kind_t cfs_kind(input logic [2:0] idx);
    case (idx)
      `CFS_IDX_EFA, `CFS_IDX_EFB, `CFS_IDX_EFC: cfs_kind = CFS_KIND_BIN;
      `CFS_IDX_LOG: cfs_kind = CFS_KIND_CYC;
      default: cfs_kind = CFS_KIND_DIR;
    endcase
  endfunction

  function automatic logic [4:0] cfs_sfi(input logic [2:0] idx);
    case (idx)
      `CFS_IDX_EFA: cfs_sfi = `CFS_SFI_EFA;
      `CFS_IDX_EFB: cfs_sfi = `CFS_SFI_EFB;
      `CFS_IDX_EFC: cfs_sfi = `CFS_SFI_EFC;
      `CFS_IDX_LOG: cfs_sfi = `CFS_SFI_LOG;
      default: cfs_sfi = `CFS_SFI_NONE;
    endcase
  endfunction
endpackage

/* File: design/cfs_ring.sv */
/*
  Cyclic record store: record pointer, age-ordered ring of records.
  Assumes strobes come from the same clock, at most one per cycle.
*/
`timescale 1ns/1ps
`include "cfs_map.svh"
module cfs_ring (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic rewind_i,
  input wire cfs_pkg::cfs_mode_t mode_i,
  input wire logic [7:0] rec_num_i,
  input wire logic [`CFS_REC_BITS-1:0] wdata_i,
  output logic found_o,
  output logic mode_ok_o,
  output logic [`CFS_REC_BITS-1:0] rdata_o
);
  logic [`CFS_REC_BITS-1:0] mem_q [`CFS_NREC];
  logic [2:0] head_q;
  logic [2:0] head_new;
  logic [3:0] ptr_q;
  logic [3:0] tgt;
  logic [3:0] sum;
  logic [2:0] slot;
  logic wr_ok;

  function automatic logic [3:0] step_fwd(input logic [3:0] p);
    step_fwd = (p == `CFS_PTR_UNSET || p == `CFS_NREC) ? `CFS_REC_FIRST : p + `CFS_REC_FIRST;
  endfunction

  function automatic logic [3:0] step_back(input logic [3:0] p);
    step_back = (p == `CFS_PTR_UNSET || p == `CFS_REC_FIRST) ? `CFS_NREC : p - `CFS_REC_FIRST;
  endfunction

  always_comb begin
    case (mode_i)
      cfs_pkg::CFS_MODE_NEXT: tgt = step_fwd(ptr_q);
      cfs_pkg::CFS_MODE_PREV: tgt = step_back(ptr_q);
      cfs_pkg::CFS_MODE_CURR: tgt = ptr_q;
      default: tgt = (rec_num_i <= {4'h0, `CFS_NREC}) ? rec_num_i[3:0] : `CFS_PTR_UNSET;
    endcase
  end

  assign found_o = (tgt != `CFS_PTR_UNSET);
  assign mode_ok_o = (mode_i == cfs_pkg::CFS_MODE_PREV);
  assign wr_ok = wr_i && mode_ok_o;
  // record k lives k-1 slots after the newest one
  assign sum = {1'b0, head_q} + tgt - `CFS_REC_FIRST;
  assign slot = (sum >= `CFS_NREC) ? 3'(sum - `CFS_NREC) : sum[2:0];
  assign rdata_o = mem_q[slot];
  assign head_new = (head_q == 3'h0) ? 3'(`CFS_NREC - `CFS_REC_FIRST) : head_q - 3'h1;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_q <= `CFS_PTR_UNSET;
    end else if (rewind_i) begin
      ptr_q <= `CFS_PTR_UNSET;
    end else if (rd_i && found_o && mode_i != cfs_pkg::CFS_MODE_ABS) begin
      ptr_q <= tgt; // failed reads keep the pointer
    end else if (wr_ok) begin
      ptr_q <= `CFS_REC_FIRST;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      head_q <= 3'h0;
    end else if (wr_ok) begin
      head_q <= head_new; // oldest slot becomes record 1
    end
  end

  // fixed count of fixed-length records
  for (genvar k = 0; k < `CFS_NREC; k++) begin : g_slot
    always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        mem_q[k] <= {4{8'(k + 1)}};
      end else if (wr_ok && head_new == 3'(k)) begin
        mem_q[k] <= wdata_i;
      end
    end
  end
endmodule

/* File: design/cfs_dir.sv */
/*
  File identifier lookup, limited to files reachable from the
  present selection, except alias 7fff, which always hits the ADF. Assumes the static table has unique names.
*/
`timescale 1ns/1ps
`include "cfs_map.svh"
module cfs_dir (
  input wire logic [15:0] fid_i,
  input wire logic [2:0] cur_dir_i,
  input wire logic [2:0] last_i,
  output logic hit_o,
  output logic [2:0] idx_o
);
  logic [`CFS_NFILE-1:0] reach;
  logic [2:0] up;

  assign up = cfs_pkg::cfs_parent(cur_dir_i);

  for (genvar k = 0; k < `CFS_NFILE; k++) begin : g_ent
    localparam logic [2:0] K = 3'(k);
    assign reach[k] = (cfs_pkg::cfs_fid(K) == fid_i) && (
      (cfs_pkg::cfs_parent(K) == cur_dir_i && K != `CFS_IDX_MF) ||
      (cfs_pkg::cfs_kind(K) == cfs_pkg::CFS_KIND_DIR && cfs_pkg::cfs_parent(K) == up) ||
      K == up || K == cur_dir_i || K == `CFS_IDX_MF || K == last_i);
  end

  always_comb begin
    hit_o = 1'b0;
    idx_o = `CFS_IDX_MF;
    if (fid_i == `CFS_FID_ALIAS) begin
      hit_o = 1'b1;
      idx_o = `CFS_IDX_ADF;
    end else begin
      // names are unique in reach, so first match is the only one
      for (int k = 0; k < `CFS_NFILE; k++) begin
        if (reach[k] && !hit_o) begin
          hit_o = 1'b1;
          idx_o = 3'(k);
        end
      end
    end
  end
endmodule

/* File: design/cfs_top.sv */
/*
  Command interpreter of a smart card file system: selection state,
  record and binary access, application command gating.
  Assumes commands arrive on the block clock with a valid/ready
  handshake and that the file table is fixed at build time.
*/
// Operation
// - cyclic file has fixed record count, length
// - next from last record wraps to 1
// - previous from record 1 wraps to last
// - newest record is 1, oldest is n
// - cyclic update only previous mode, else 6981
// - reads support next, previous, current, absolute
// - failed command leaves record pointer unchanged
// - unset pointer: next gives 1, previous last
// - select reports record length in descriptor
// - previous after update returns old second-last
// - file identifier fixed at creation, used selecting
// - no duplicate identifiers under one parent
// - nearby directories' children have distinct identifiers
// - short file numbers unique under one parent
// - application names unique across the card
// - 7fff aliases the active application directory
// - directory selection sets current directory
// - directory selection clears current elementary file
// - elementary selection keeps parent as directory
// - application command only for current directory
// - reachable set from last selected file
// - reselecting last selected file succeeds
// - binary read without current file gives 6986
// - success ends with status 9000
`timescale 1ns/1ps
`include "cfs_map.svh"
module cfs_top (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i,
  input wire cfs_pkg::cfs_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output cfs_pkg::cfs_rsp_t rsp_o,
  output logic [2:0] cur_dir_o,
  output logic cur_ef_valid_o,
  output logic [2:0] cur_ef_o
);
  cfs_pkg::cfs_state_t state_q;
  cfs_pkg::cfs_rsp_t rsp_q;
  cfs_pkg::cfs_rsp_t rsp_d;
  logic [2:0] cur_dir_q;
  logic [2:0] cur_ef_q;
  logic ef_valid_q;
  logic [2:0] last_q;
  logic take;
  logic sel_hit;
  logic [2:0] sel_idx;
  cfs_pkg::cfs_kind_t sel_kind;
  cfs_pkg::cfs_kind_t ef_kind;
  logic on_cyclic;
  logic ring_rd;
  logic ring_wr;
  logic ring_rewind;
  logic ring_found;
  logic ring_mode_ok;
  logic [`CFS_REC_BITS-1:0] ring_rdata;

  // record commands only reach the ring when a cyclic file is current
  function automatic logic is_op(input cfs_pkg::cfs_op_t got, input cfs_pkg::cfs_op_t want);
    is_op = (got == want);
  endfunction

  assign take = cmd_valid_i && (state_q == cfs_pkg::CFS_IDLE);
  assign cmd_ready_o = (state_q == cfs_pkg::CFS_IDLE);
  assign rsp_valid_o = (state_q == cfs_pkg::CFS_RESP);
  assign rsp_o = rsp_q;
  assign cur_dir_o = cur_dir_q;
  assign cur_ef_valid_o = ef_valid_q;
  assign cur_ef_o = cur_ef_q;

  assign sel_kind = cfs_pkg::cfs_kind(sel_idx);
  assign ef_kind = cfs_pkg::cfs_kind(cur_ef_q);
  assign on_cyclic = ef_valid_q && (ef_kind == cfs_pkg::CFS_KIND_CYC);

  assign ring_rd = take && on_cyclic && is_op(cmd_i.op, cfs_pkg::CFS_OP_READ_REC);
  assign ring_wr = take && on_cyclic && is_op(cmd_i.op, cfs_pkg::CFS_OP_UPDATE_REC);
  assign ring_rewind = take && is_op(cmd_i.op, cfs_pkg::CFS_OP_SELECT) && sel_hit &&
                       sel_kind == cfs_pkg::CFS_KIND_CYC;

  cfs_dir u_dir (
    .fid_i(cmd_i.file_identifier),
    .cur_dir_i(cur_dir_q),
    .last_i(last_q),
    .hit_o(sel_hit),
    .idx_o(sel_idx)
  );

  cfs_ring u_ring (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .rd_i(ring_rd),
    .wr_i(ring_wr),
    .rewind_i(ring_rewind),
    .mode_i(cmd_i.mode),
    .rec_num_i(cmd_i.rec_num),
    .wdata_i(cmd_i.wdata),
    .found_o(ring_found),
    .mode_ok_o(ring_mode_ok),
    .rdata_o(ring_rdata)
  );

  // one command in flight: response one cycle after take
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= cfs_pkg::CFS_IDLE;
    end else begin
      case (state_q)
        cfs_pkg::CFS_IDLE: begin
          if (cmd_valid_i) begin
            state_q <= cfs_pkg::CFS_RESP;
          end
        end
        default: begin
          state_q <= cfs_pkg::CFS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rsp_d = '0;
    rsp_d.sw = `CFS_SW_OK;
    case (cmd_i.op)
      cfs_pkg::CFS_OP_SELECT: begin
        if (!sel_hit) begin
          rsp_d.sw = `CFS_SW_NOT_FOUND;
        end else begin
          rsp_d.file_identifier = cfs_pkg::cfs_fid(sel_idx);
          rsp_d.short_file_number = cfs_pkg::cfs_sfi(sel_idx);
          rsp_d.desc_tag = `CFS_TAG_DESC;
          if (sel_kind == cfs_pkg::CFS_KIND_CYC) begin
            rsp_d.rec_len = `CFS_REC_BYTES; // descriptor bytes 5 and 6
            rsp_d.rec_cnt = {4'h0, `CFS_NREC};
          end
        end
      end
      cfs_pkg::CFS_OP_READ_REC: begin
        if (!ef_valid_q) begin
          rsp_d.sw = `CFS_SW_NO_EF;
        end else if (!on_cyclic) begin
          rsp_d.sw = `CFS_SW_BAD_STRUCT;
        end else if (!ring_found) begin
          rsp_d.sw = `CFS_SW_NO_REC;
        end else begin
          rsp_d.data = ring_rdata;
        end
      end
      cfs_pkg::CFS_OP_UPDATE_REC: begin
        if (!ef_valid_q) begin
          rsp_d.sw = `CFS_SW_NO_EF;
        end else if (!on_cyclic || !ring_mode_ok) begin
          rsp_d.sw = `CFS_SW_BAD_STRUCT;
        end
      end
      cfs_pkg::CFS_OP_READ_BIN: begin
        if (!ef_valid_q) begin
          rsp_d.sw = `CFS_SW_NO_EF;
        end else if (ef_kind != cfs_pkg::CFS_KIND_BIN) begin
          rsp_d.sw = `CFS_SW_BAD_STRUCT;
        end else begin
          rsp_d.data = {16'h0000, cfs_pkg::cfs_fid(cur_ef_q)};
        end
      end
      cfs_pkg::CFS_OP_APP: begin
        if (cmd_i.app_dir != cur_dir_q) begin
          rsp_d.sw = `CFS_SW_COND;
        end
      end
      cfs_pkg::CFS_OP_STATUS: begin
        rsp_d.file_identifier = cfs_pkg::cfs_fid(cur_dir_q);
        rsp_d.desc_tag = `CFS_TAG_DESC;
      end
      default: begin
        rsp_d.sw = `CFS_SW_BAD_INS;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_q <= '0;
    end else if (take) begin
      rsp_q <= rsp_d;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_dir_q <= `CFS_IDX_MF;
    end else if (take && is_op(cmd_i.op, cfs_pkg::CFS_OP_SELECT) && sel_hit) begin
      if (sel_kind == cfs_pkg::CFS_KIND_DIR) begin
        cur_dir_q <= sel_idx;
      end else begin
        cur_dir_q <= cfs_pkg::cfs_parent(sel_idx);
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ef_valid_q <= 1'b0;
      cur_ef_q <= `CFS_IDX_MF;
    end else if (take && is_op(cmd_i.op, cfs_pkg::CFS_OP_SELECT) && sel_hit) begin
      if (sel_kind == cfs_pkg::CFS_KIND_DIR) begin
        ef_valid_q <= 1'b0;
      end else begin
        ef_valid_q <= 1'b1;
        cur_ef_q <= sel_idx;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_q <= `CFS_IDX_MF;
    end else if (take && is_op(cmd_i.op, cfs_pkg::CFS_OP_SELECT) && sel_hit) begin
      last_q <= sel_idx;
    end
  end
endmodule

/* File: tb/cfs_top_assertions.sv */
/*
  Port checker of cfs_top, bound into every instance.
  Assumes cfs_pkg is compiled first.
*/
`timescale 1ns/1ps
module cfs_top_chk (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i,
  input wire cfs_pkg::cfs_cmd_t cmd_i,
  input wire logic cmd_ready_o,
  input wire logic rsp_valid_o,
  input wire cfs_pkg::cfs_rsp_t rsp_o,
  input wire logic [2:0] cur_dir_o,
  input wire logic cur_ef_valid_o,
  input wire logic [2:0] cur_ef_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic tk;
  logic sel;
  logic ok;
  assign tk = cmd_valid_i && cmd_ready_o;
  assign sel = tk && cmd_i.op == cfs_pkg::CFS_OP_SELECT;
  assign ok = rsp_o.sw == 16'h9000;
  a_take_answer: assert property (
    tk |=> rsp_valid_o && !cmd_ready_o) else $error("no answer after take");
  a_rsp_pulse: assert property (
    rsp_valid_o |=> !rsp_valid_o && cmd_ready_o) else $error("answer too long");
  a_bin_no_ef: assert property (
    tk && cmd_i.op == cfs_pkg::CFS_OP_READ_BIN && !cur_ef_valid_o |=> rsp_o.sw == 16'h6986)
    else $error("binary read without file");
  a_upd_mode: assert property (
    tk && cmd_i.op == cfs_pkg::CFS_OP_UPDATE_REC && cur_ef_valid_o && cur_ef_o == 3'h7
    && cmd_i.mode != cfs_pkg::CFS_MODE_PREV |=> rsp_o.sw == 16'h6981)
    else $error("update mode not refused");
  a_err_hold: assert property (
    rsp_valid_o && !ok |-> $stable(cur_dir_o) && $stable(cur_ef_valid_o) && $stable(cur_ef_o))
    else $error("state moved on error");
  a_master_sel: assert property (
    sel && cmd_i.file_identifier == 16'h3f00 |=> ok && cur_dir_o == 3'h0 && !cur_ef_valid_o)
    else $error("master select wrong");
  a_alias_sel: assert property (
    sel && cmd_i.file_identifier == 16'h7fff |=> ok && cur_dir_o == 3'h1 && !cur_ef_valid_o)
    else $error("alias select wrong");
  a_cyc_desc: assert property (
    sel && cmd_i.file_identifier == 16'h6f80 |=> !ok || (rsp_o.desc_tag == 8'h82
    && rsp_o.rec_len == 16'h0004 && cur_dir_o == 3'h1 && cur_ef_valid_o && cur_ef_o == 3'h7))
    else $error("cyclic select wrong");
  a_app_gate: assert property (
    tk && cmd_i.op == cfs_pkg::CFS_OP_APP && cmd_i.app_dir != cur_dir_o
    |=> rsp_o.sw == 16'h6985) else $error("app command not refused");
endmodule
bind cfs_top cfs_top_chk i_chk (
  .clock_i(clock_i),
  .arst_n_i(arst_n_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i),
  .cmd_ready_o(cmd_ready_o),
  .rsp_valid_o(rsp_valid_o),
  .rsp_o(rsp_o),
  .cur_dir_o(cur_dir_o),
  .cur_ef_valid_o(cur_ef_valid_o),
  .cur_ef_o(cur_ef_o)
);

/* File: tb/cfs_term.sv */
/*
  Terminal model: one command at a time over valid/ready.
  Assumes the bench calls send and checks every status word.
*/
`timescale 1ns/1ps
module cfs_term (
  input wire logic clock_i,
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output cfs_pkg::cfs_cmd_t cmd_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // held until taken, then lines inverted
  task automatic send(input cfs_pkg::cfs_cmd_t c);
    @(negedge clock_i);
    cmd_o = c;
    cmd_valid_o = 1'b1;
    while (cmd_ready_i !== 1'b1) @(negedge clock_i);
    @(negedge clock_i);
    cmd_valid_o = 1'b0;
    cmd_o = ~c;
  endtask
endmodule

/* File: tb/tb_card_file_select_cyclic_records.sv */
/*
  Self-checking bench of cfs_top; a monitor compares answers with queued notes.
  Assumes the fixed file table and reset record contents.
*/
`timescale 1ns/1ps
module tb_card_file_select_cyclic_records;
  typedef struct packed {
    logic [15:0] sw;
    logic [31:0] d;
    logic m;
  } cfs_exp_t;
  localparam cfs_pkg::cfs_op_t op_rd = cfs_pkg::CFS_OP_READ_REC;
  localparam cfs_pkg::cfs_op_t op_up = cfs_pkg::CFS_OP_UPDATE_REC;
  localparam cfs_pkg::cfs_op_t op_bin = cfs_pkg::CFS_OP_READ_BIN;
  localparam cfs_pkg::cfs_op_t op_app = cfs_pkg::CFS_OP_APP;
  localparam cfs_pkg::cfs_mode_t m_nx = cfs_pkg::CFS_MODE_NEXT;
  localparam cfs_pkg::cfs_mode_t m_pv = cfs_pkg::CFS_MODE_PREV;
  localparam cfs_pkg::cfs_mode_t m_cu = cfs_pkg::CFS_MODE_CURR;
  localparam cfs_pkg::cfs_mode_t m_ab = cfs_pkg::CFS_MODE_ABS;
  localparam logic [15:0] sw_ok = 16'h9000;
  logic clock_i;
  logic arst_n_i;
  logic cmd_valid_i;
  cfs_pkg::cfs_cmd_t cmd_i;
  logic cmd_ready_o;
  logic rsp_valid_o;
  cfs_pkg::cfs_rsp_t rsp_o;
  logic [2:0] cur_dir_o;
  logic cur_ef_valid_o;
  logic [2:0] cur_ef_o;
  cfs_exp_t q[$];
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] wd;
  logic [31:0] old;
  cfs_top i_dut (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i),
    .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o),
    .rsp_o(rsp_o),
    .cur_dir_o(cur_dir_o),
    .cur_ef_valid_o(cur_ef_valid_o),
    .cur_ef_o(cur_ef_o)
  );
  cfs_term i_term (
    .clock_i(clock_i),
    .cmd_ready_i(cmd_ready_o),
    .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i)
  );
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic bad(input string s);
    n_errors++;
    $display("MISMATCH %0t %s", $time, s);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_rsp(input cfs_exp_t e);
    total_checks++;
    if (rsp_o.sw !== e.sw || (e.m && rsp_o.data !== e.d)) bad("response");
  endtask
  task automatic chk_dir(input logic [2:0] dir, input logic v, input logic [2:0] ef);
    total_checks++;
    if (cur_dir_o !== dir || cur_ef_valid_o !== v || (v && cur_ef_o !== ef)) bad("selection");
  endtask
  task automatic chk_fcp(input logic [15:0] f, input logic [4:0] s, input logic [15:0] l,
      input logic [7:0] n);
    total_checks++;
    if (rsp_o.file_identifier !== f || rsp_o.short_file_number !== s || rsp_o.rec_len !== l || rsp_o.rec_cnt !== n) begin
      bad("descriptor");
    end
  endtask
  task automatic tx(input cfs_pkg::cfs_op_t op, input cfs_pkg::cfs_mode_t md,
      input logic [15:0] f, input logic [15:0] sw, input logic [31:0] d = '0,
      input logic m = 1'b0);
    cfs_pkg::cfs_cmd_t c;
    c = '{op, md, f[7:0], f, f[2:0], wd};
    q.push_back('{sw, d, m});
    i_term.send(c);
  endtask
  task automatic rd(input cfs_pkg::cfs_mode_t md, input logic [7:0] n,
      input logic [15:0] sw, input logic [31:0] d);
    tx(op_rd, md, {8'h00, n}, sw, d, sw == sw_ok);
  endtask
  task automatic sel(input logic [15:0] f, input logic [15:0] sw);
    tx(cfs_pkg::CFS_OP_SELECT, m_nx, f, sw);
  endtask
  function automatic logic [31:0] rv(input logic [7:0] k);
    rv = {4{k}};
  endfunction
  always @(negedge clock_i) begin
    if (rsp_valid_o === 1'b1) begin
      if (q.size() == 0) bad("unexpected answer");
      else chk_rsp(q.pop_front());
    end
  end
  initial begin
    #(25 * 4000);
    bad("timeout");
    end_sim();
  end
  initial begin
    void'($urandom(7773));
    wd = $urandom();
    arst_n_i = 1'b0;
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    arst_n_i = 1'b1;
    tx(op_bin, m_nx, 16'h0, 16'h6986);
    sel(16'h7f01, sw_ok);
    chk_dir(3'h1, 1'b0, 3'h0);
    sel(16'h6f80, sw_ok);
    chk_fcp(16'h6f80, 5'h04, 16'h0004, 8'h08);
    chk_dir(3'h1, 1'b1, 3'h7);
    rd(m_nx, 8'h0, sw_ok, rv(8'h1));
    rd(m_pv, 8'h0, sw_ok, rv(8'h8));
    rd(m_nx, 8'h0, sw_ok, rv(8'h1));
    rd(m_pv, 8'h0, sw_ok, rv(8'h8));
    for (int i = 0; i < 4; i++) begin
      if (i != 1) tx(op_up, cfs_pkg::cfs_mode_t'(i[1:0]), 16'h1, 16'h6981);
    end
    rd(m_cu, 8'h0, sw_ok, rv(8'h8));
    tx(op_up, m_pv, 16'h0, sw_ok);
    rd(m_ab, 8'h1, sw_ok, wd);
    rd(m_pv, 8'h0, sw_ok, rv(8'h7));
    for (int k = 2; k <= 8; k++) rd(m_ab, k[7:0], sw_ok, rv(k[7:0] - 8'h1));
    rd(m_ab, 8'h0, 16'h6a83, '0);
    rd(m_ab, 8'h9, 16'h6a83, '0);
    old = wd;
    wd = $urandom();
    tx(op_up, m_pv, 16'h0, sw_ok);
    rd(m_ab, 8'h1, sw_ok, wd);
    rd(m_ab, 8'h2, sw_ok, old);
    sel(16'h6f80, sw_ok);
    rd(m_cu, 8'h0, 16'h6a83, '0);
    tx(op_bin, m_nx, 16'h0, 16'h6981);
    tx(op_app, m_nx, 16'h1, sw_ok);
    tx(op_app, m_nx, 16'h2, 16'h6985);
    sel(16'h7fff, sw_ok);
    chk_dir(3'h1, 1'b0, 3'h0);
    sel(16'h7f10, sw_ok);
    tx(cfs_pkg::CFS_OP_STATUS, m_nx, 16'h0, sw_ok);
    chk_fcp(16'h7f10, 5'h00, 16'h0000, 8'h00);
    sel(16'h6fad, 16'h6a82);
    chk_dir(3'h2, 1'b0, 3'h0);
    sel(16'h6f3a, sw_ok);
    chk_dir(3'h2, 1'b1, 3'h5);
    rd(m_nx, 8'h0, 16'h6981, '0);
    tx(op_up, m_pv, 16'h0, 16'h6981);
    tx(op_bin, m_nx, 16'h0, sw_ok, 32'h00006f3a, 1'b1);
    sel(16'h3f00, sw_ok);
    chk_dir(3'h0, 1'b0, 3'h0);
    tx(op_bin, m_nx, 16'h0, 16'h6986);
    rd(m_nx, 8'h0, 16'h6986, '0);
    sel(16'h2fe2, sw_ok);
    chk_fcp(16'h2fe2, 5'h02, 16'h0000, 8'h00);
    tx(op_bin, m_nx, 16'h0, sw_ok, 32'h00002fe2, 1'b1);
    tx(cfs_pkg::cfs_op_t'(3'h6), m_nx, 16'h0, 16'h6d00);
    repeat (3) @(negedge clock_i);
    total_checks++;
    if (q.size() != 0) bad("missing answer");
    end_sim();
  end
endmodule
